// [src/drop_code_if.sv]
// Interface carrying the two three-level phase-drop code lines.
`timescale 1ns/1ps
interface drop_code_if;
    import phase_shed_pkg::*;
    level_type drop_code_line_a;
    level_type drop_code_line_b;
    modport master (output drop_code_line_a, output drop_code_line_b);
    modport slave  (input  drop_code_line_a, input  drop_code_line_b);
endinterface : drop_code_if

// [src/phase_shed_master.sv]
// Master end: phase-count decision, fast add, faults and registers.
`timescale 1ns/1ps
// Summary of operation
// - Six-phase max restores at 89, 85, 81 percent.
// - Four-phase max restores at 89, 86 percent.
// - Three-phase max restores at 89 percent.
// - Dropped phase output held at mid-level.
// - Dropping ramps duty to zero over 15 cycles.
// - At or above threshold, add back one step at a time.
// - Phase at 85 percent peak restores all.
// - Dropping inhibited 1.5 ms after fast restore.
// - Per-channel overcurrent blanked 200 us after fast add.
// - Only master decides; slaves follow.
// - Master drives code lines; slaves read them.
// - Code: HH 6, MH 4, LH 3, HL 2, LL off.
// - Constant-current reference defaults 2.4 V, programmable.
// - Average overcurrent sets fault bit, flag low.
// - Enable needs input above rising threshold.
// - Enable low clears faults, stops everything.
// - Dropping only with tri-state driver option.
// - Dropping only when reference below disable level.
module phase_shed_master #(
    parameter int ref_width    = 10,
    parameter int rearm_count  = phase_shed_pkg::rearm_clocks,
    parameter int blank_count  = phase_shed_pkg::blank_clocks,
    parameter int hyst         = 8
) (
    // Clock and reset
    input  wire logic                      mclk,
    input  wire logic                      arst_n,
    // Analog front end, as digitised levels
    input  wire logic                      enable_above_rise,
    input  wire logic                      enable_below_fall,
    input  wire logic                      tri_state_option,
    input  wire logic                      drop_disable_level,
    input  wire logic [ref_width-1:0]      drop_reference_level,
    input  wire logic [ref_width-1:0]      current_monitor,
    input  wire logic                      avg_oc_compare,
    input  wire logic                      phase_peak_85,
    input  wire logic                      per_channel_overcurrent,
    input  wire phase_shed_pkg::max_phase_type max_phases,
    input  wire logic                      switch_cycle_start,
    // Register port
    input  wire logic [7:0]                reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_write,
    input  wire logic                      reg_read,
    output logic      [7:0]                reg_rdata,
    // Outputs
    output logic      [2:0]                active_phases,
    output logic      [5:0]                phase_mid_level,
    output logic      [3:0]                drop_ramp_step,
    output logic      [2:0]                cc_reference,
    output logic                           oc_trip,
    output logic                           fault_flag_out_n,
    output logic                           irq,
    output logic                           device_on,
    // Code lines to slaves
    drop_code_if.master                    code
);
    import phase_shed_pkg::*;

    localparam int pw = ref_width + 7;

    logic              on_q;
    logic [2:0]        cnt_q, cnt_d;
    logic [2:0]        dropping_q;
    logic [3:0]        ramp_q;
    logic [31:0]       rearm_q, blank_q;
    logic [2:0]        cc_q;
    logic              aoc_q;
    logic [2:0]        ist_q, ien_q;
    logic [7:0]        rdata_q;
    logic              add_req_q, drop_req_q, fast_q;

    wire logic [pw-1:0] imon100 = pw'(current_monitor) * pw'(100);
    wire logic [pw-1:0] ref_s   = pw'(drop_reference_level);
    wire logic [pw-1:0] hyst_s  = pw'(hyst) * pw'(100);
    // Add threshold for the next step up from the present count.
    logic [pw-1:0] add_thr;
    logic [2:0]    up_cnt, max_cnt;
    always_comb begin
        add_thr = '0;
        up_cnt  = cnt_q;
        max_cnt = 3'd6;
        case (max_phases)
            max_six: begin
                max_cnt = 3'd6;
                case (cnt_q)
                    3'd2: begin add_thr = ref_s * pw'(pct_six_2to3); up_cnt = 3'd3; end
                    3'd3: begin add_thr = ref_s * pw'(pct_six_3to4); up_cnt = 3'd4; end
                    3'd4: begin add_thr = ref_s * pw'(pct_six_4to6); up_cnt = 3'd6; end
                    default: add_thr = '1;
                endcase
            end
            max_four: begin
                max_cnt = 3'd4;
                case (cnt_q)
                    3'd2: begin add_thr = ref_s * pw'(pct_four_2to3); up_cnt = 3'd3; end
                    3'd3: begin add_thr = ref_s * pw'(pct_four_3to4); up_cnt = 3'd4; end
                    default: add_thr = '1;
                endcase
            end
            max_three: begin
                max_cnt = 3'd3;
                if (cnt_q == 3'd2) begin
                    add_thr = ref_s * pw'(pct_three_2to3);
                    up_cnt  = 3'd3;
                end else begin
                    add_thr = '1;
                end
            end
            default: begin
                max_cnt = 3'd6;
                add_thr = '1;
            end
        endcase
    end

    // Drop threshold is the add threshold of the step below, less hysteresis.
    logic [2:0]    dn_cnt;
    logic [pw-1:0] drop_thr;
    always_comb begin
        dn_cnt   = cnt_q;
        drop_thr = '0;
        case (cnt_q)
            3'd6: begin dn_cnt = 3'd4; drop_thr = ref_s * pw'(pct_six_4to6); end
            3'd4: begin
                dn_cnt   = 3'd3;
                drop_thr = ref_s * pw'((max_phases == max_six) ? pct_six_3to4
                                                               : pct_four_3to4);
            end
            3'd3: begin
                dn_cnt   = 3'd2;
                drop_thr = ref_s * pw'((max_phases == max_six) ? pct_six_2to3 :
                           (max_phases == max_four) ? pct_four_2to3
                                                    : pct_three_2to3);
            end
            default: drop_thr = '0;
        endcase
    end

    wire logic shed_ok = on_q && tri_state_option && !drop_disable_level;
    wire logic below   = (imon100 + hyst_s) < drop_thr;
    wire logic above   = imon100 >= add_thr;
    wire logic cyc     = switch_cycle_start;
    wire logic ramp_done = (ramp_q == 4'(ramp_cycles));

    // Count decision: adds and drops on switching-cycle boundaries, restores to max at once.
    always_comb begin
        cnt_d = cnt_q;
        if (!shed_ok) begin
            cnt_d = max_cnt;
        end else if (fast_q) begin
            cnt_d = max_cnt;
        end else if (cyc && add_req_q) begin
            cnt_d = up_cnt;
        end else if (cyc && ramp_done && dropping_q != 3'd0) begin
            cnt_d = dropping_q;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            on_q <= 1'b0;
        end else begin
            on_q <= enable_above_rise ? 1'b1 : enable_below_fall ? 1'b0 : on_q;
        end
    end

    // Comparator results sampled once a clock before use.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            add_req_q  <= 1'b0;
            drop_req_q <= 1'b0;
            fast_q     <= 1'b0;
        end else begin
            add_req_q  <= above && cnt_q < max_cnt;
            drop_req_q <= below && rearm_q == 0 && cnt_q > 3'd2;
            fast_q     <= shed_ok && phase_peak_85 && cnt_q != max_cnt;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q      <= 3'd6;
            dropping_q <= 3'd0;
            ramp_q     <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
            if (!shed_ok || fast_q || add_req_q) begin
                dropping_q <= 3'd0;
                ramp_q     <= 4'h0;
            end else if (cyc && dropping_q == 3'd0 && drop_req_q) begin
                dropping_q <= dn_cnt;
                ramp_q     <= 4'h1;
            end else if (cyc && dropping_q != 3'd0) begin
                dropping_q <= ramp_done ? 3'd0 : dropping_q;
                ramp_q     <= ramp_done ? 4'h0 : ramp_q + 4'h1;
            end
        end
    end

    // Re-arm delay and overcurrent blanking after a fast restore.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rearm_q <= '0;
            blank_q <= '0;
        end else if (fast_q || (phase_peak_85 && shed_ok)) begin
            rearm_q <= 32'(rearm_count);
            blank_q <= 32'(blank_count);
        end else begin
            rearm_q <= (rearm_q != 0) ? rearm_q - 32'd1 : rearm_q;
            blank_q <= (blank_q != 0) ? blank_q - 32'd1 : blank_q;
        end
    end

    // Registers, faults and interrupts.
    wire logic wr_cc  = reg_write && reg_addr == cc_threshold_control_addr;
    wire logic wr_clr = reg_write && reg_addr == irq_clear_addr;
    wire logic wr_en  = reg_write && reg_addr == irq_enable_addr;
    wire logic aoc_ev = on_q && avg_oc_compare;
    wire logic [2:0] ev = {cnt_d != cnt_q, fast_q, aoc_ev && !aoc_q};
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cc_q  <= cc_thresh_reset;
            aoc_q <= 1'b0;
            ist_q <= '0;
            ien_q <= '0;
        end else if (!on_q) begin
            cc_q  <= cc_thresh_reset;
            aoc_q <= 1'b0;
            ist_q <= '0;
            ien_q <= ien_q;
        end else begin
            cc_q  <= wr_cc ? reg_wdata[2:0] : cc_q;
            aoc_q <= aoc_q | aoc_ev;
            ist_q <= (ist_q & ~(wr_clr ? reg_wdata[2:0] : 3'h0)) | ev;
            ien_q <= wr_en ? reg_wdata[2:0] : ien_q;
        end
    end

    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr)
            fault_status_four_addr:    rd_mux = 8'(aoc_q) << aoc_fault_bit;
            cc_threshold_control_addr: rd_mux = {5'h00, cc_q};
            irq_status_addr:           rd_mux = {5'h00, ist_q};
            irq_enable_addr:           rd_mux = {5'h00, ien_q};
            phase_status_addr:         rd_mux = {5'h00, cnt_q};
            default:                   rd_mux = 8'h0_0;
        endcase
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 8'h0_0;
        end else begin
            rdata_q <= reg_read ? rd_mux : 8'h0_0;
        end
    end

    // Phase count to code lines.
    level_type la, lb;
    always_comb begin
        la = lvl_low;
        lb = lvl_low;
        if (shed_ok) begin
            case (cnt_q)
                3'd6: begin la = lvl_high; lb = lvl_high; end
                3'd4: begin la = lvl_mid;  lb = lvl_high; end
                3'd3: begin la = lvl_low;  lb = lvl_high; end
                3'd2: begin la = lvl_high; lb = lvl_low;  end
                default: begin la = lvl_low; lb = lvl_low; end
            endcase
        end
    end
    assign code.drop_code_line_a = la;
    assign code.drop_code_line_b = lb;

    genvar g;
    for (g = 0; g < 6; g++) begin : g_mid
        assign phase_mid_level[g] = !on_q || (tri_state_option && (g >= cnt_q));
    end
    assign reg_rdata        = rdata_q;
    assign active_phases    = cnt_q;
    assign drop_ramp_step   = ramp_q;
    assign cc_reference     = cc_q;
    assign oc_trip          = on_q && per_channel_overcurrent && blank_q == 0;
    assign fault_flag_out_n = !aoc_q;
    assign irq              = |(ist_q & ien_q);
    assign device_on        = on_q;
endmodule : phase_shed_master

// [src/phase_shed_pkg.sv]
// Package of constants and types shared by the master and slave ends.
package phase_shed_pkg;
    // Software register offsets.
    localparam logic [7:0] fault_status_four_addr    = 8'hD5;
    localparam logic [7:0] cc_threshold_control_addr = 8'hED;
    localparam logic [7:0] irq_status_addr           = 8'hE0;
    localparam logic [7:0] irq_clear_addr            = 8'hE1;
    localparam logic [7:0] irq_enable_addr           = 8'hE2;
    localparam logic [7:0] drop_config_addr          = 8'hE3;
    localparam logic [7:0] phase_status_addr         = 8'hE4;
    // Field positions and reset values.
    localparam int         aoc_fault_bit     = 5;
    localparam logic [2:0] cc_thresh_reset   = 3'h4;
    localparam logic [2:0] drop_cfg_reset    = 3'h0;
    localparam int         irq_aoc_bit       = 0;
    localparam int         irq_fast_bit      = 1;
    localparam int         irq_count_bit     = 2;
    // Restore fractions of the drop reference, in percent.
    localparam int pct_six_4to6   = 89;
    localparam int pct_six_3to4   = 85;
    localparam int pct_six_2to3   = 81;
    localparam int pct_four_3to4  = 89;
    localparam int pct_four_2to3  = 86;
    localparam int pct_three_2to3 = 89;
    localparam int pct_fast_add   = 85;
    // Timing in switching cycles and in microseconds.
    localparam int ramp_cycles    = 15;
    localparam int clk_mhz        = 50;
    localparam int rearm_us       = 1500;
    localparam int blank_us       = 200;
    localparam int rearm_clocks   = rearm_us * clk_mhz;
    localparam int blank_clocks   = blank_us * clk_mhz;
    // Three-level line coding.
    typedef enum logic [1:0] {
        lvl_low  = 2'b00,
        lvl_mid  = 2'b01,
        lvl_high = 2'b10
    } level_type;
    typedef enum logic [1:0] {
        max_six   = 2'b00,
        max_four  = 2'b01,
        max_three = 2'b10
    } max_phase_type;
endpackage : phase_shed_pkg

// [src/phase_shed_slave.sv]
// Slave end: decodes the master's phase-drop code into an active count.
`timescale 1ns/1ps
module phase_shed_slave (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       arst_n,
    // User side
    input  wire logic       tri_state_option,
    input  wire logic [2:0] max_count,
    input  wire logic       switch_cycle_start,
    output logic      [2:0] active_phases,
    output logic      [5:0] phase_mid_level,
    output logic            drop_enabled,
    // Code lines from the master
    drop_code_if.slave      code
);
    import phase_shed_pkg::*;

    logic [2:0] cnt_q, code_cnt;
    logic       en_q;

    // The slave never decides; it only maps the received code.
    always_comb begin
        code_cnt = max_count;
        case ({code.drop_code_line_a, code.drop_code_line_b})
            {lvl_high, lvl_high}: code_cnt = 3'd6;
            {lvl_mid, lvl_high}:  code_cnt = 3'd4;
            {lvl_low, lvl_high}:  code_cnt = 3'd3;
            {lvl_high, lvl_low}:  code_cnt = 3'd2;
            default:              code_cnt = max_count;
        endcase
    end
    wire logic off_code = code.drop_code_line_a == lvl_low &&
                          code.drop_code_line_b == lvl_low;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 3'd6;
            en_q  <= 1'b0;
        end else if (!tri_state_option || off_code) begin
            cnt_q <= max_count;
            en_q  <= 1'b0;
        end else if (switch_cycle_start) begin
            cnt_q <= (code_cnt > max_count) ? max_count : code_cnt;
            en_q  <= 1'b1;
        end
    end

    genvar g;
    for (g = 0; g < 6; g++) begin : g_mid
        assign phase_mid_level[g] = tri_state_option && (g >= cnt_q);
    end
    assign active_phases = cnt_q;
    assign drop_enabled  = en_q;
endmodule : phase_shed_slave

// [verif/phase_shedding_control_asserts.sv]
// Checker for the drop code lines and the master's phase-count outputs.
`timescale 1ns/1ps
module phase_shedding_control_asserts #(
    parameter int rearm_count = 50,
    parameter int blank_count = 20
) (
    // Clock and reset
    input wire logic                          mclk,
    input wire logic                          arst_n,
    // Code lines
    input wire phase_shed_pkg::level_type     drop_code_line_a,
    input wire phase_shed_pkg::level_type     drop_code_line_b,
    // Master side
    input wire logic [2:0]                    active_phases,
    input wire logic [3:0]                    drop_ramp_step,
    input wire logic                          switch_cycle_start,
    input wire logic                          phase_peak_85,
    input wire phase_shed_pkg::max_phase_type max_phases,
    input wire logic                          tri_state_option,
    input wire logic                          drop_disable_level,
    input wire logic                          per_channel_overcurrent,
    input wire logic                          oc_trip,
    input wire logic                          avg_oc_compare,
    input wire logic                          device_on,
    input wire logic                          fault_flag_out_n
);
    import phase_shed_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic        live;
    logic [2:0]  max_n;
    int unsigned since_q;
    assign live  = !(drop_code_line_a == lvl_low && drop_code_line_b == lvl_low);
    assign max_n = (max_phases == max_six) ? 3'h6 :
                   (max_phases == max_four) ? 3'h4 : 3'h3;
    function automatic logic [3:0] enc(input logic [2:0] n);
        case (n)
            3'h6:    enc = {lvl_high, lvl_high};
            3'h4:    enc = {lvl_mid, lvl_high};
            3'h3:    enc = {lvl_low, lvl_high};
            3'h2:    enc = {lvl_high, lvl_low};
            default: enc = 4'hF;
        endcase
    endfunction : enc
    // Clocks since the last fast restore; the first cycles are left loose
    // because the design may take up to two cycles to react.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            since_q <= 0;
        end else if (phase_peak_85 && live) begin
            since_q <= 1;
        end else if (since_q != 0 && since_q < rearm_count) begin
            since_q <= since_q + 1;
        end else begin
            since_q <= 0;
        end
    end
    a_code_legal: assert property (
        drop_code_line_b != lvl_mid &&
        (drop_code_line_a != lvl_mid || drop_code_line_b == lvl_high))
        else $error("illegal level pair on the drop code lines");
    a_code_count: assert property (
        live |-> {drop_code_line_a, drop_code_line_b} == enc(active_phases))
        else $error("drop code disagrees with the active count");
    a_fast_restore: assert property (
        phase_peak_85 && live |-> ##[1:2] active_phases == max_n)
        else $error("fast restore did not reach the maximum count");
    a_rearm_hold: assert property (
        since_q > 2 |-> active_phases >= $past(active_phases))
        else $error("phase dropped inside the re-arm delay");
    a_blank_oc: assert property (
        since_q > 2 && since_q < blank_count - 2 |-> !oc_trip)
        else $error("overcurrent tripped inside the blanking time");
    a_oc_pass: assert property (
        per_channel_overcurrent && device_on && since_q == 0 |-> oc_trip)
        else $error("overcurrent not reported outside blanking");
    a_drop_ramp: assert property (
        live && $past(live) && active_phases < $past(active_phases)
        |-> $past(switch_cycle_start) && $past(drop_ramp_step) == 4'hF)
        else $error("count lowered without a full ramp");
    a_ramp_step: assert property (
        drop_ramp_step != 0 && drop_ramp_step != $past(drop_ramp_step)
        |-> $past(switch_cycle_start) &&
            drop_ramp_step == $past(drop_ramp_step) + 4'h1)
        else $error("ramp step moved off a cycle boundary");
    a_tri_off: assert property (
        (!tri_state_option && device_on) [*6] |-> !live && active_phases == max_n)
        else $error("dropping active without the tri-state option");
    a_level_off: assert property (
        (drop_disable_level && device_on) [*6] |-> !live && active_phases == max_n)
        else $error("dropping active above the disable level");
    a_aoc_flag: assert property (
        avg_oc_compare && device_on |-> ##[1:2] !fault_flag_out_n)
        else $error("average overcurrent did not pull the flag low");
endmodule : phase_shedding_control_asserts

// [verif/phase_shedding_control_tb_top.sv]
// Testbench joining the master and slave ends over the drop code lines.
`timescale 1ns/1ps
module phase_shedding_control_tb_top;
    import phase_shed_pkg::*;
    localparam int rearm_n = 50;
    localparam int blank_n = 20;
    logic mclk = 1'b0, arst_n = 1'b0, enable_above_rise = 1'b1;
    logic enable_below_fall = 1'b0, tri_state_option = 1'b1;
    logic drop_disable_level = 1'b0, avg_oc_compare = 1'b0;
    logic phase_peak_85 = 1'b0, per_channel_overcurrent = 1'b0;
    logic switch_cycle_start = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic [9:0] drop_reference_level = 10'h190, current_monitor = 10'h000;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [2:0] active_phases, s_active, cc_reference, slave_max;
    logic [5:0] phase_mid_level, s_mid;
    logic [3:0] drop_ramp_step;
    logic [1:0] div_q = 2'h0;
    logic oc_trip, fault_flag_out_n, irq, device_on, s_en;
    max_phase_type max_phases = max_six;
    int fails = 0;
    int comparisons = 0;
    max_phase_type mode_tab[6] = '{max_six, max_six, max_six,
                                   max_four, max_four, max_three};
    int         pct_tab[6] = '{81, 85, 89, 86, 89, 89};
    logic [2:0] nxt_tab[6] = '{3'h3, 3'h4, 3'h6, 3'h3, 3'h4, 3'h3};
    assign slave_max = (max_phases == max_six) ? 3'h6 :
                       (max_phases == max_four) ? 3'h4 : 3'h3;
    drop_code_if u_drop_code_if ();
    phase_shed_master #(.rearm_count(rearm_n), .blank_count(blank_n))
    u_phase_shed_master (
        .mclk, .arst_n, .enable_above_rise, .enable_below_fall,
        .tri_state_option, .drop_disable_level, .drop_reference_level,
        .current_monitor, .avg_oc_compare, .phase_peak_85,
        .per_channel_overcurrent, .max_phases, .switch_cycle_start,
        .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .active_phases, .phase_mid_level, .drop_ramp_step, .cc_reference,
        .oc_trip, .fault_flag_out_n, .irq, .device_on,
        .code(u_drop_code_if.master));
    phase_shed_slave u_phase_shed_slave (
        .mclk, .arst_n, .tri_state_option, .max_count(slave_max),
        .switch_cycle_start, .active_phases(s_active),
        .phase_mid_level(s_mid), .drop_enabled(s_en),
        .code(u_drop_code_if.slave));
    phase_shedding_control_asserts #(.rearm_count(rearm_n),
        .blank_count(blank_n)) u_phase_shedding_control_asserts (
        .mclk, .arst_n, .active_phases, .drop_ramp_step,
        .drop_code_line_a(u_drop_code_if.drop_code_line_a),
        .drop_code_line_b(u_drop_code_if.drop_code_line_b),
        .switch_cycle_start, .phase_peak_85, .max_phases, .tri_state_option,
        .drop_disable_level, .per_channel_overcurrent, .oc_trip,
        .avg_oc_compare, .device_on, .fault_flag_out_n);
    initial forever #10 mclk = ~mclk;
    // A switching-cycle boundary every four clocks keeps ramps short.
    always @(posedge mclk) begin
        div_q <= div_q + 2'h1;
        switch_cycle_start <= (div_q == 2'h3);
    end
    task automatic give_verdict();
        if (fails == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask : rdchk
    task automatic do_reset();
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask : do_reset
    // Waits for a count, then checks both ends and the mid-level outputs.
    task automatic wait_cnt(input logic [2:0] n);
        int k;
        k = 0;
        while (active_phases !== n && k < 900) begin
            @(posedge mclk);
            k++;
        end
        repeat (6) @(posedge mclk);
        chk(active_phases, n);
        chk(s_active, n);
        chk(phase_mid_level, 6'(6'h3F << n));
        chk(s_mid, 6'(6'h3F << n));
        chk(s_en, 1'b1);
    endtask : wait_cnt
    initial begin
        repeat (30000) @(posedge mclk);
        fails++;
        give_verdict();
    end
    initial begin
        int         thr;
        logic [2:0] cur;
        logic [7:0] d;
        thr = $urandom(96);
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rdchk(cc_threshold_control_addr, 8'h04);
        chk(cc_reference, cc_thresh_reset);
        wr(cc_threshold_control_addr, 8'h03);
        rdchk(cc_threshold_control_addr, 8'h03);
        chk(cc_reference, 3'h3);
        rdchk(8'h10, 8'h00);
        wr(fault_status_four_addr, 8'hFF);
        rdchk(fault_status_four_addr, 8'h00);
        cur = 3'h2;
        for (int i = 0; i < 6; i++) begin
            if (i == 0 || i == 3 || i == 5) begin
                max_phases <= mode_tab[i];
                drop_reference_level <= 10'($urandom_range(900, 200));
                current_monitor <= 10'h000;
                do_reset();
                wait_cnt(3'h2);
                cur = 3'h2;
            end
            thr = (int'(drop_reference_level) * pct_tab[i] + 99) / 100;
            current_monitor <= 10'(thr - 1);
            repeat (40) @(posedge mclk);
            chk(active_phases, cur);
            current_monitor <= 10'(thr);
            wait_cnt(nxt_tab[i]);
            cur = nxt_tab[i];
            rdchk(phase_status_addr, {5'h00, cur});
        end
        max_phases <= max_six;
        current_monitor <= 10'h000;
        do_reset();
        wait_cnt(3'h2);
        wr(irq_clear_addr, 8'h07);
        wr(irq_enable_addr, 8'h01);
        phase_peak_85 <= 1'b1;
        @(posedge mclk);
        phase_peak_85 <= 1'b0;
        repeat (3) @(posedge mclk);
        per_channel_overcurrent <= 1'b1;
        @(posedge mclk);
        chk(active_phases, 3'h6);
        chk(oc_trip, 1'b0);
        chk(irq, 1'b0);
        repeat (blank_n) @(posedge mclk);
        chk(oc_trip, 1'b1);
        chk(active_phases, 3'h6);
        per_channel_overcurrent <= 1'b0;
        rd(irq_status_addr, d);
        chk(d[irq_fast_bit], 1'b1);
        wait_cnt(3'h2);
        wr(irq_clear_addr, 8'h07);
        avg_oc_compare <= 1'b1;
        @(posedge mclk);
        avg_oc_compare <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(fault_flag_out_n, 1'b0);
        chk(irq, 1'b1);
        rdchk(fault_status_four_addr, 8'h20);
        wr(irq_clear_addr, 8'h07);
        @(posedge mclk);
        chk(irq, 1'b0);
        chk(fault_flag_out_n, 1'b0);
        enable_above_rise <= 1'b0;
        enable_below_fall <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(device_on, 1'b0);
        chk(fault_flag_out_n, 1'b1);
        chk(phase_mid_level, 6'h3F);
        rdchk(fault_status_four_addr, 8'h00);
        wr(cc_threshold_control_addr, 8'h01);
        enable_above_rise <= 1'b1;
        enable_below_fall <= 1'b0;
        repeat (4) @(posedge mclk);
        chk(device_on, 1'b1);
        rdchk(cc_threshold_control_addr, 8'h04);
        for (int j = 0; j < 2; j++) begin
            tri_state_option <= (j == 1);
            drop_disable_level <= (j == 1);
            repeat (20) @(posedge mclk);
            chk(active_phases, 3'h6);
            chk(s_active, 3'h6);
            chk(s_en, 1'b0);
            tri_state_option <= 1'b1;
            drop_disable_level <= 1'b0;
            wait_cnt(3'h2);
        end
        give_verdict();
    end
endmodule : phase_shedding_control_tb_top
